// File: icsc_pkg.sv
/*
  Package for the internal clock source controller: register offsets,
  field positions, reset values, mode encodings and wake-up timing.
  Assumes a 50 MHz system clock and a 32-bit AHB-Lite register bus.
*/
`default_nettype none
package icsc_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_TRIM = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_STOPCTL = 8'h10;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SRC_SEL_BIT = 6;
  localparam int KEEP_STOP_BIT = 0;
  localparam int DIV_LO = 6;
  localparam int LP_BIT = 3;
  localparam int STATUS_BIT = 2;
  localparam int FINE_BIT = 0;
  localparam int STOP_REQ_BIT = 0;
  localparam int STOP_MODE_BIT = 1;
  localparam int WAKE_BUSY_BIT = 2;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] DIV_RESET = 2'h1;
  localparam logic [7:0] TRIM_DEFAULT = 8'h80;
  // ---------------------------------------------------------------
  // wake-up timing, microseconds, and cycles at 50 MHz
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int REF_WAKE_TIME_US = 6;
  localparam int LOOP_WAKE_TIME_US = 60;
  localparam int REF_WAKE_CYC = REF_WAKE_TIME_US * CLK_MHZ;
  localparam int LOOP_WAKE_CYC = LOOP_WAKE_TIME_US * CLK_MHZ;
  // source-select synchroniser depth
  localparam int SYNC_STAGES = 2;
  // ---------------------------------------------------------------
  // modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_ENGAGED = 3'b000,
    ST_BYPASS = 3'b001,
    ST_BYPASS_LP = 3'b010,
    ST_STOP = 3'b011,
    ST_WAKE = 3'b100
  } icsc_state_t;
endpackage
`default_nettype wire

// File: icsc_ctrl.sv
/*
  Internal clock source controller: mode control, stop handling,
  wake-up delays, bus divider enables, trim registers, status readback.
  Assumes a single 50 MHz clock; the loop and reference oscillators are
  modelled as input enables (LOOP_TICK, REF_TICK) from the analog side.
*/
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - divider field codes 0..3 divide selected source by 1,2,4,8
// - divider field resets to divide by two
// - low-power bit disables the loop only in bypass modes
// - eight-bit coarse trim, larger value means longer period
// - fine trim bit lengthens period when set, shortens when clear
// - status bit follows source select after synchronisation only
// - RESET or source select written 0 gives loop engaged mode
// - engaged mode clocks system output from loop ticks
// - select 1 with low-power 0 gives bypass with loop running
// - select 1 with low-power 1 gives bypass with loop off
// - stop halts all clocks; reference output runs if keep bit set
// - interrupt exit from stop restores previous mode
// - exit waits reference wake if keep clear, loop re-acquisition if kept from engaged, else none
// - divider changes take effect immediately
// - trim values survive RESET; POR reloads the defaults
// - fixed clock is reference halved, valid only in engaged mode
// - source select bit 6 picks loop (0) or reference (1)
// - keep-in-stop bit 0 keeps reference running in stop
// - bus clock is half the system clock output
module icsc_ctrl
#(
  parameter int REF_WAKE = icsc_pkg::REF_WAKE_CYC,
  parameter int LOOP_WAKE = icsc_pkg::LOOP_WAKE_CYC
)
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic POR,
  input wire logic LOOP_TICK,
  input wire logic REF_TICK,
  input wire logic STOP_REQ,
  input wire logic WAKE_IRQ,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic SYS_CLK_EN,
  output logic BUS_CLK_EN,
  output logic REF_CLK_EN,
  output logic FIXED_CLK_EN,
  output logic FIXED_CLK_VALID,
  output logic LOOP_ENABLE,
  output logic [7:0] COARSE_TRIM,
  output logic FINE_TRIM
);
  // wake counters are 16 bits wide; refuse counts they cannot hold
  if (REF_WAKE < 1 || LOOP_WAKE < 1 || REF_WAKE > 65535 ||
      LOOP_WAKE > 65535)
  begin : gen_bad_wake
    $error("wake counts out of range");
  end

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic src_sel_r, src_sel_nxt;
  logic keep_stop_r, keep_stop_nxt;
  logic [1:0] div_r, div_nxt;
  logic lp_r, lp_nxt;
  logic [7:0] trim_r, trim_nxt;
  logic fine_r, fine_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic trim_init_r, trim_init_nxt;
  logic [icsc_pkg::SYNC_STAGES-1:0] sync_r, sync_nxt;
  logic status_r, status_nxt;
  icsc_pkg::icsc_state_t state_r, state_nxt, saved_r, saved_nxt;
  logic [15:0] wake_cnt_r, wake_cnt_nxt;
  logic [3:0] div_cnt_r, div_cnt_nxt;
  logic sys_half_r, sys_half_nxt;
  logic ref_half_r, ref_half_nxt;
  logic sys_tick;
  logic take;

  // read value for a given address
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      icsc_pkg::OFF_CTRL1:
      begin
        v[icsc_pkg::SRC_SEL_BIT] = src_sel_r;
        v[icsc_pkg::KEEP_STOP_BIT] = keep_stop_r;
      end
      icsc_pkg::OFF_CTRL2:
      begin
        v[icsc_pkg::DIV_LO +: 2] = div_r;
        v[icsc_pkg::LP_BIT] = lp_r;
      end
      icsc_pkg::OFF_TRIM: v[7:0] = trim_r;
      icsc_pkg::OFF_STAT:
      begin
        v[icsc_pkg::STATUS_BIT] = status_r;
        v[icsc_pkg::FINE_BIT] = fine_r;
      end
      icsc_pkg::OFF_STOPCTL:
      begin
        v[icsc_pkg::STOP_MODE_BIT] = (state_r == icsc_pkg::ST_STOP);
        v[icsc_pkg::WAKE_BUSY_BIT] = (state_r == icsc_pkg::ST_WAKE);
      end
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  assign take = HSEL && HREADY && HTRANS[1];
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_r;

  // register writes land in the data phase; trims start at a default
  // on each power-on and are never touched by RESET
  always_comb
  begin
    src_sel_nxt = src_sel_r;
    keep_stop_nxt = keep_stop_r;
    div_nxt = div_r;
    lp_nxt = lp_r;
    trim_nxt = trim_r;
    fine_nxt = fine_r;
    trim_init_nxt = 1'b1;
    wr_pend_nxt = take && HWRITE;
    wr_addr_nxt = HADDR[7:0];
    rdata_nxt = (take && !HWRITE) ? rd_mux(HADDR[7:0]) : rdata_r;
    if (!trim_init_r)
    begin
      trim_nxt = icsc_pkg::TRIM_DEFAULT;
      fine_nxt = 1'b0;
    end
    if (wr_pend_r)
    begin
      case (wr_addr_r)
        icsc_pkg::OFF_CTRL1:
        begin
          src_sel_nxt = HWDATA[icsc_pkg::SRC_SEL_BIT];
          keep_stop_nxt = HWDATA[icsc_pkg::KEEP_STOP_BIT];
        end
        icsc_pkg::OFF_CTRL2:
        begin
          div_nxt = HWDATA[icsc_pkg::DIV_LO +: 2];
          lp_nxt = HWDATA[icsc_pkg::LP_BIT];
        end
        icsc_pkg::OFF_TRIM: trim_nxt = HWDATA[7:0];
        icsc_pkg::OFF_STAT: fine_nxt = HWDATA[icsc_pkg::FINE_BIT];
        default: ;
      endcase
    end
  end

  // control registers; trims sit outside the reset
  always_ff @(posedge CLK)
  begin
    trim_r <= trim_nxt;
    fine_r <= fine_nxt;
    if (POR)
      trim_init_r <= 1'b0;
    else
      trim_init_r <= trim_init_nxt;
    if (RESET)
    begin
      src_sel_r <= 1'b0;
      keep_stop_r <= 1'b0;
      div_r <= icsc_pkg::DIV_RESET;
      lp_r <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r <= 32'h0;
    end
    else
    begin
      src_sel_r <= src_sel_nxt;
      keep_stop_r <= keep_stop_nxt;
      div_r <= div_nxt;
      lp_r <= lp_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // mode control
  // ---------------------------------------------------------------
  // select is resynchronised on loop/ref ticks so the mux only moves
  // between source pulses; status tracks the mux, not the write
  always_comb
  begin
    sync_nxt = sync_r;
    status_nxt = status_r;
    state_nxt = state_r;
    saved_nxt = saved_r;
    wake_cnt_nxt = wake_cnt_r;
    if (LOOP_TICK || REF_TICK)
      sync_nxt = {sync_r[icsc_pkg::SYNC_STAGES-2:0], src_sel_r};
    status_nxt = sync_r[icsc_pkg::SYNC_STAGES-1];
    case (state_r)
      icsc_pkg::ST_ENGAGED, icsc_pkg::ST_BYPASS, icsc_pkg::ST_BYPASS_LP:
      begin
        if (!status_r)
          state_nxt = icsc_pkg::ST_ENGAGED;
        else if (lp_r)
          state_nxt = icsc_pkg::ST_BYPASS_LP;
        else
          state_nxt = icsc_pkg::ST_BYPASS;
        if (STOP_REQ)
        begin
          saved_nxt = state_r;
          state_nxt = icsc_pkg::ST_STOP;
        end
      end
      icsc_pkg::ST_STOP:
      begin
        if (WAKE_IRQ)
        begin
          state_nxt = icsc_pkg::ST_WAKE;
          if (!keep_stop_r)
            wake_cnt_nxt = 16'(REF_WAKE - 1);
          else if (saved_r == icsc_pkg::ST_ENGAGED)
            wake_cnt_nxt = 16'(LOOP_WAKE - 1);
          else
            wake_cnt_nxt = 16'h0;
        end
      end
      icsc_pkg::ST_WAKE:
      begin
        if (wake_cnt_r == 16'h0)
          state_nxt = saved_r;
        else
          wake_cnt_nxt = wake_cnt_r - 16'h1;
      end
      default: state_nxt = icsc_pkg::ST_ENGAGED;
    endcase
  end

  // mode registers
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      sync_r <= '0;
      status_r <= 1'b0;
      state_r <= icsc_pkg::ST_ENGAGED;
      saved_r <= icsc_pkg::ST_ENGAGED;
      wake_cnt_r <= 16'h0;
    end
    else
    begin
      sync_r <= sync_nxt;
      status_r <= status_nxt;
      state_r <= state_nxt;
      saved_r <= saved_nxt;
      wake_cnt_r <= wake_cnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // clock enables
  // ---------------------------------------------------------------
  logic running;
  assign running = (state_r == icsc_pkg::ST_ENGAGED) ||
                   (state_r == icsc_pkg::ST_BYPASS) ||
                   (state_r == icsc_pkg::ST_BYPASS_LP);
  // source mux follows the settled mode, so engaged
  // never borrows a reference tick while the state catches up
  assign sys_tick = running &&
                    ((state_r == icsc_pkg::ST_ENGAGED) ? LOOP_TICK :
                     REF_TICK);

  // divider counter: a tick every 2^div system ticks
  always_comb
  begin
    div_cnt_nxt = div_cnt_r;
    sys_half_nxt = sys_half_r;
    ref_half_nxt = ref_half_r;
    SYS_CLK_EN = 1'b0;
    if (sys_tick)
    begin
      div_cnt_nxt = div_cnt_r + 4'h1;
      // divide by 1,2,4,8 from live field
      if ((div_cnt_r & ((4'h1 << div_r) - 4'h1)) == 4'h0)
        SYS_CLK_EN = 1'b1;
    end
    if (SYS_CLK_EN)
      sys_half_nxt = !sys_half_r;
    if (REF_TICK && REF_CLK_EN)
      ref_half_nxt = !ref_half_r;
  end

  // divider registers
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      div_cnt_r <= 4'h0;
      sys_half_r <= 1'b0;
      ref_half_r <= 1'b0;
    end
    else
    begin
      div_cnt_r <= div_cnt_nxt;
      sys_half_r <= sys_half_nxt;
      ref_half_r <= ref_half_nxt;
    end
  end

  // bus runs at half the system output
  assign BUS_CLK_EN = SYS_CLK_EN && sys_half_r;
  // reference survives stop only when kept
  assign REF_CLK_EN = REF_TICK &&
                      (running || keep_stop_r ||
                       state_r == icsc_pkg::ST_WAKE);
  assign FIXED_CLK_EN = REF_TICK && ref_half_r && running;
  assign FIXED_CLK_VALID = (state_r == icsc_pkg::ST_ENGAGED);
  // loop off in low-power bypass and in stop
  assign LOOP_ENABLE = (state_r == icsc_pkg::ST_ENGAGED) ||
                       (state_r == icsc_pkg::ST_BYPASS) ||
                       (state_r == icsc_pkg::ST_WAKE &&
                        saved_r != icsc_pkg::ST_BYPASS_LP);
  assign COARSE_TRIM = trim_r;
  assign FINE_TRIM = fine_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  bus_div_reset_a:
  assert property (@(posedge CLK) RESET |=> div_r == icsc_pkg::DIV_RESET)
  else $error("divider not reset to two");
  lp_loop_off_a:
  assert property (@(posedge CLK) disable iff (RESET)
    state_r == icsc_pkg::ST_BYPASS_LP |-> !LOOP_ENABLE)
  else $error("loop running in low-power bypass");
  status_lag_a:
  assert property (@(posedge CLK) disable iff (RESET)
    $rose(src_sel_r) |-> !status_r)
  else $error("status followed write at once");
  engaged_src_a:
  assert property (@(posedge CLK) disable iff (RESET)
    state_r == icsc_pkg::ST_ENGAGED && !LOOP_TICK |-> !SYS_CLK_EN)
  else $error("engaged clock not from loop");
  stop_quiet_a:
  assert property (@(posedge CLK) disable iff (RESET)
    state_r == icsc_pkg::ST_STOP && !keep_stop_r |->
    !SYS_CLK_EN && !REF_CLK_EN)
  else $error("clock running in stop");
  stop_return_a:
  assert property (@(posedge CLK) disable iff (RESET)
    state_r == icsc_pkg::ST_WAKE && wake_cnt_r == 16'h0 |=>
    state_r == $past(saved_r))
  else $error("wrong mode after stop");
  wake_delay_a:
  assert property (@(posedge CLK) disable iff (RESET)
    state_r == icsc_pkg::ST_STOP && WAKE_IRQ && !keep_stop_r |=>
    state_r == icsc_pkg::ST_WAKE && wake_cnt_r == 16'(REF_WAKE - 1))
  else $error("reference wake delay wrong");
  fixed_valid_a:
  assert property (@(posedge CLK) disable iff (RESET)
    FIXED_CLK_VALID |-> state_r == icsc_pkg::ST_ENGAGED)
  else $error("fixed clock valid outside engaged");
  bus_half_a:
  assert property (@(posedge CLK) disable iff (RESET)
    BUS_CLK_EN |-> SYS_CLK_EN)
  else $error("bus tick without system tick");
endmodule
`default_nettype wire

// File: icsc_ctrl_tb.sv
/*
  Self-checking bench for icsc_ctrl: bus access, divider, modes, trim,
  stop and wake. Assumes icsc_pkg is compiled first; ticks run freely except while t_modes withholds loop ticks.
*/
`timescale 1ns/1ps
`default_nettype none
module icsc_ctrl_tb;
  // short wake counts keep the run brief yet tell the two apart
  localparam int RW = 8;
  localparam int LW = 40;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic por = 1'b1;
  logic loop_tick = 1'b0;
  logic ref_tick = 1'b0;
  logic stop_req = 1'b0;
  logic wake_irq = 1'b0;
  logic loop_hold = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, sys_en, bus_en, ref_en, fix_en, fix_ok, loop_en;
  logic [7:0] coarse;
  logic fine;
  logic [3:0] ens;
  logic [31:0] q;
  int bad_count = 0;
  int cmp_count = 0;
  int c;
  assign ens = {fix_en, ref_en, bus_en, sys_en};

  icsc_ctrl #(.REF_WAKE(RW), .LOOP_WAKE(LW)) DUT (
    .CLK(clk), .RESET(reset), .POR(por), .LOOP_TICK(loop_tick),
    .REF_TICK(ref_tick), .STOP_REQ(stop_req), .WAKE_IRQ(wake_irq),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .SYS_CLK_EN(sys_en),
    .BUS_CLK_EN(bus_en), .REF_CLK_EN(ref_en), .FIXED_CLK_EN(fix_en),
    .FIXED_CLK_VALID(fix_ok), .LOOP_ENABLE(loop_en),
    .COARSE_TRIM(coarse), .FINE_TRIM(fine)
  );

  // clock and oscillator ticks: loop every cycle, reference every other
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    loop_tick <= !loop_hold;
    ref_tick <= ~ref_tick;
  end

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // wait on the slave's ready at a rising edge; the watchdog bounds it
  task wait_rdy;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
  endtask

  // starts just after a rising edge, whatever the caller last waited on
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  // count pulses of one enable over n cycles, sampled mid-cycle
  task cnt(input int sel, input int n);
    c = 0;
    repeat (n)
    begin
      @(negedge clk);
      if (ens[sel] === 1'b1)
        c++;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    bus(1'b0, icsc_pkg::OFF_CTRL2, 32'h0);
    chk("div", 32'h1, q[7:6]);
    chk("lp", 32'h0, q[3]);
    bus(1'b0, icsc_pkg::OFF_CTRL1, 32'h0);
    chk("ctrl1", 32'h0, q);
    chk("fixok", 32'h1, fix_ok);
    chk("loop", 32'h1, loop_en);
    chk("coarse", 32'h80, coarse);
    chk("fine", 32'h0, fine);
    chk("resp", 32'h0, hresp);
  endtask

  // every code, counted right after the write lands
  task t_div;
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, icsc_pkg::OFF_CTRL2, k << 6); // trimmed already
      cnt(0, 64);
      chk("sys", 64 >> k, c);
      cnt(1, 64);
      chk("bus", 32 >> k, c);
    end
    bus(1'b1, icsc_pkg::OFF_CTRL2, 32'h0);
  endtask

  task t_modes;
    bus(1'b1, icsc_pkg::OFF_CTRL1, 32'h40);
    bus(1'b0, icsc_pkg::OFF_STAT, 32'h0);
    chk("stat0", 32'h0, q[2]);
    repeat (10) @(posedge clk);
    chk("byp", 32'h1, {fix_ok, loop_en});
    bus(1'b0, icsc_pkg::OFF_STAT, 32'h0);
    chk("stat1", 32'h1, q[2]);
    cnt(0, 64);
    chk("refsys", 32'd32, c);
    bus(1'b1, icsc_pkg::OFF_CTRL2, 32'h8);
    repeat (3) @(posedge clk);
    chk("lpbyp", 32'h0, {fix_ok, loop_en});
    bus(1'b1, icsc_pkg::OFF_CTRL1, 32'h0);
    repeat (10) @(posedge clk);
    chk("lpeng", 32'h3, {fix_ok, loop_en});
    cnt(0, 64);
    chk("loopsys", 32'd64, c);
    cnt(3, 64);
    chk("fixed", 32'd16, c);
    // loop ticks withheld: engaged mode must not borrow the reference
    @(posedge clk);
    loop_hold <= 1'b1;
    repeat (3) @(posedge clk);
    cnt(0, 16);
    chk("noloop", 32'h0, c);
    @(posedge clk);
    loop_hold <= 1'b0;
    repeat (2) @(posedge clk);
    bus(1'b1, icsc_pkg::OFF_CTRL2, 32'h0);
  endtask

  task t_trim;
    bus(1'b1, icsc_pkg::OFF_TRIM, 32'h5A);
    bus(1'b1, icsc_pkg::OFF_STAT, 32'h1);
    repeat (4) @(posedge clk);
    chk("coarse", 32'h5A, coarse);
    chk("fine", 32'h1, fine);
    bus(1'b0, icsc_pkg::OFF_TRIM, 32'h0);
    chk("trimrd", 32'h5A, q[7:0]);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    chk("keepc", 32'h5A, coarse);
    chk("keepf", 32'h1, fine);
    bus(1'b0, icsc_pkg::OFF_CTRL2, 32'h0);
    chk("divrst", 32'h1, q[7:6]);
    bus(1'b1, icsc_pkg::OFF_CTRL2, 32'h0);
  endtask

  // enter stop from a chosen mode, wake, measure the delay
  task t_stop(input logic keep, input logic sel, input int w);
    int n;
    bus(1'b1, icsc_pkg::OFF_CTRL1, {25'h0, sel, 5'h0, keep});
    repeat (10) @(posedge clk);
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    cnt(0, 20);
    chk("stopsys", 32'h0, c);
    cnt(2, 20);
    chk("stopref", keep, c != 0);
    bus(1'b0, icsc_pkg::OFF_STOPCTL, 32'h0);
    chk("instop", 32'h1, q[1]);
    wake_irq <= 1'b1;
    @(posedge clk);
    wake_irq <= 1'b0;
    n = 0;
    while (sys_en !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    chk("wake", 32'h1, n >= w - 2 && n <= w + 4);
    chk("back", !sel, fix_ok);
  endtask

  // a reset while stopped must land in the default mode
  task t_stop_reset;
    bus(1'b1, icsc_pkg::OFF_CTRL1, 32'h40);
    // settle in bypass first, so restoring would differ from default
    repeat (10) @(posedge clk);
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    repeat (4) @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk("rststop", 32'h1, fix_ok);
    bus(1'b0, icsc_pkg::OFF_CTRL1, 32'h0);
    chk("rstsel", 32'h0, q);
  endtask

  task t_unmap;
    bus(1'b1, 8'h20, 32'hFFFF_FFFF);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmap", 32'h0, q);
    chk("resp", 32'h0, hresp);
  endtask

  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // main sequence; trims loaded by power-on along with reset
  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    por <= 1'b0;
    t_reset();
    t_trim();
    t_div();
    t_modes();
    t_stop(1'b0, 1'b1, RW);
    t_stop(1'b1, 1'b0, LW);
    t_stop_reset();
    t_unmap();
    wrap_up();
  end

  // watchdog well beyond the thousand or so cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
